/* File: inc/fpr_regs.vh */
`ifndef FPR_REGS_VH
`define FPR_REGS_VH
`define FPR_CLK_MHZ            50
`define FPR_CLK_PERIOD_NS      20
`define FPR_SELECT_ACCESS_NS   70
`define FPR_ADDR_ACCESS_NS     70
`define FPR_SLEEP_MARGIN_NS    30
`define FPR_MIN_RESET_PULSE_NS 500
`define FPR_POST_RESET_READ_NS 50
`define FPR_SETTLE_BUSY_NS     20000
`define FPR_SETTLE_IDLE_NS     500
`define FPR_CYC_UP(ns)   (((ns) + `FPR_CLK_PERIOD_NS - 1) / `FPR_CLK_PERIOD_NS)
`define FPR_CYC_DN(ns)   (((ns) / `FPR_CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `FPR_CLK_PERIOD_NS))
`define FPR_SELECT_CYC   `FPR_CYC_UP(`FPR_SELECT_ACCESS_NS)
`define FPR_ACCESS_CYC   `FPR_CYC_UP(`FPR_ADDR_ACCESS_NS)
`define FPR_SLEEP_CYC    `FPR_CYC_UP(`FPR_ADDR_ACCESS_NS + `FPR_SLEEP_MARGIN_NS)
`define FPR_RESET_CYC    `FPR_CYC_UP(`FPR_MIN_RESET_PULSE_NS)
`define FPR_RH_CYC       `FPR_CYC_UP(`FPR_POST_RESET_READ_NS)
`define FPR_BUSY_CYC     `FPR_CYC_UP(`FPR_SETTLE_BUSY_NS)
`define FPR_IDLE_CYC     `FPR_CYC_UP(`FPR_SETTLE_IDLE_NS)
`define FPR_BOOT_NIBBLE  4'h_f
`define FPR_SECT_BOOT32  5'h_0f
`define FPR_SECT_BOOT8A  5'h_10
`define FPR_SECT_BOOT8B  5'h_11
`define FPR_SECT_BOOT16  5'h_12
`endif

/* File: src/fpr_sector_decode.v */
`timescale 1ns/1ps
`include "fpr_regs.vh"
module fpr_sector_decode (
  input  wire [6:0] i_sect_addr,
  output wire [4:0] o_sector
);
  // Only A18..A12 matter; lower bits select within a sector
  function [4:0] fpr_decode;
    input [6:0] a;
    begin
      if (a[6:3] != `FPR_BOOT_NIBBLE)
        fpr_decode = {1'b0, a[6:3]};
      else if (!a[2])
        fpr_decode = `FPR_SECT_BOOT32;
      else if (a[1])
        fpr_decode = `FPR_SECT_BOOT16;
      else if (!a[0])
        fpr_decode = `FPR_SECT_BOOT8A;
      else
        fpr_decode = `FPR_SECT_BOOT8B;
    end
  endfunction
  assign o_sector = fpr_decode(i_sect_addr);
endmodule

/* File: src/fpr_host.v */
`timescale 1ns/1ps
`include "fpr_regs.vh"
module fpr_host (
  input  wire        i_ref_clk,
  input  wire        i_srst,
  input  wire        i_rd_req,
  input  wire        i_wr_req,
  input  wire        i_rst_req,
  input  wire        i_byte_mode,
  input  wire [19:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_busy_op,
  input  wire [15:0] i_dq_in,
  input  wire        i_op_done_indicator,
  output reg         o_ready,
  output reg         o_rd_valid,
  output reg  [15:0] o_rdata,
  output reg  [4:0]  o_sector,
  output reg         o_restart_needed,
  output reg         o_dev_standby,
  output reg  [18:0] o_addr_pin,
  output reg  [15:0] o_dq_out,
  output reg  [15:0] o_dq_oe_n,
  output reg         o_chip_enable_low,
  output reg         o_output_gate_low,
  output reg         o_write_strobe_low,
  output reg         o_array_restart_low,
  output reg         o_byte_low
);
  localparam ST_START = 3'd0;
  localparam ST_IDLE  = 3'd1;
  localparam ST_READ  = 3'd2;
  localparam ST_WRITE = 3'd3;
  localparam ST_RST   = 3'd4;
  localparam ST_SETL  = 3'd5;
  localparam ST_RH    = 3'd6;
  localparam ST_WREC  = 3'd7;
  parameter BUSY_CYC = `FPR_BUSY_CYC;
  parameter IDLE_CYC = `FPR_IDLE_CYC;

  reg  [2:0]  state;
  reg  [15:0] cnt;
  reg         was_busy;
  wire [16:0] pin_raw;
  wire [16:0] pin_sync;
  wire [15:0] dq_s2;
  wire        rdy_s2;
  wire [4:0]  sector;
  wire [18:0] pin_addr;

  // Byte mode drives A18..A0 plus the low bit on the DQ15 line
  assign pin_addr = i_byte_mode ? i_addr[19:1] : i_addr[18:0];

  fpr_sector_decode u_dec (
    .i_sect_addr (pin_addr[18:12]),
    .o_sector    (sector)
  );

  assign pin_raw = {i_op_done_indicator, i_dq_in};
  assign dq_s2   = pin_sync[15:0];
  assign rdy_s2  = pin_sync[16];

  // Pins come from the device unclocked; each bit gets its own two-stage chain
  genvar gi;
  generate
    for (gi = 0; gi < 17; gi = gi + 1) begin : g_sync
      reg stage1;
      reg stage2;
      always @(posedge i_ref_clk) begin
        stage1 <= pin_raw[gi];
        stage2 <= stage1;
      end
      assign pin_sync[gi] = stage2;
    end
  endgenerate

  // Access length in cycles; reads add two for the data synchroniser
  function fpr_hold_done;
    input [15:0] count;
    input        is_read;
    begin
      if (is_read)
        fpr_hold_done = count >= `FPR_SELECT_CYC + 2;
      else
        fpr_hold_done = count >= `FPR_ACCESS_CYC;
    end
  endfunction

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state               <= ST_START;
      cnt                 <= 16'h_0000;
      was_busy            <= 1'b0;
      o_ready             <= 1'b0;
      o_rd_valid          <= 1'b0;
      o_rdata             <= 16'h_0000;
      o_sector            <= 5'h_00;
      o_restart_needed    <= 1'b0;
      o_dev_standby       <= 1'b0;
      o_addr_pin          <= 19'h_0_0000;
      o_dq_out            <= 16'h_0000;
      o_dq_oe_n           <= 16'h_ffff;
      o_chip_enable_low   <= 1'b1;
      o_output_gate_low   <= 1'b1;
      o_write_strobe_low  <= 1'b1;
      o_array_restart_low <= 1'b0;
      o_byte_low          <= 1'b1;
    end else begin
      o_rd_valid <= 1'b0;
      case (state)
        ST_START: begin
          // Chip enable held off through reset at power up
          was_busy <= 1'b1;
          cnt      <= 16'h_0000;
          state    <= ST_RST;
        end
        ST_IDLE: begin
          o_ready       <= 1'b1;
          o_dev_standby <= 1'b1;
          if (i_rst_req) begin
            o_ready             <= 1'b0;
            o_dev_standby       <= 1'b0;
            was_busy            <= ~rdy_s2 | i_busy_op;
            // Bus let go so the reset pulse finds it floating
            o_dq_oe_n           <= 16'h_ffff;
            o_array_restart_low <= 1'b0;
            cnt                 <= 16'h_0000;
            state               <= ST_RST;
          end else if (i_rd_req || i_wr_req) begin
            o_ready            <= 1'b0;
            o_dev_standby      <= 1'b0;
            o_addr_pin         <= pin_addr;
            o_sector           <= sector;
            o_byte_low         <= ~i_byte_mode;
            o_chip_enable_low  <= 1'b0;
            cnt                <= 16'h_0000;
            if (i_wr_req) begin
              o_restart_needed   <= 1'b0;
              o_dq_out           <= i_byte_mode ? {i_addr[0], 7'h_00, i_wdata[7:0]} : i_wdata;
              o_dq_oe_n          <= i_byte_mode ? 16'h_7f00 : 16'h_0000;
              o_write_strobe_low <= 1'b0;
              state              <= ST_WRITE;
            end else begin
              o_dq_out          <= {i_addr[0], 15'h_0000};
              o_dq_oe_n         <= i_byte_mode ? 16'h_7fff : 16'h_ffff;
              o_output_gate_low <= 1'b0;
              state             <= ST_READ;
            end
          end
        end
        ST_READ: begin
          cnt <= cnt + 16'h_0001;
          // Device is deselected after every access, so select time always applies
          if (fpr_hold_done(cnt, 1'b1)) begin
            o_rdata           <= o_byte_low ? dq_s2 : {8'h_00, dq_s2[7:0]};
            o_rd_valid        <= 1'b1;
            o_chip_enable_low <= 1'b1;
            o_output_gate_low <= 1'b1;
            o_dq_oe_n         <= 16'h_ffff;
            state             <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          cnt <= cnt + 16'h_0001;
          if (fpr_hold_done(cnt, 1'b0)) begin
            o_write_strobe_low <= 1'b1;
            o_chip_enable_low  <= 1'b1;
            cnt                <= 16'h_0000;
            state              <= ST_WREC;
          end
        end
        ST_WREC: begin
          // Data stays driven one cycle past the strobe for hold time
          o_dq_oe_n <= 16'h_ffff;
          state     <= ST_IDLE;
        end
        ST_RST: begin
          cnt <= cnt + 16'h_0001;
          if (cnt >= `FPR_RESET_CYC - 1) begin
            o_array_restart_low <= 1'b1;
            cnt                 <= 16'h_0000;
            state               <= ST_SETL;
          end
        end
        ST_SETL: begin
          cnt <= cnt + 16'h_0001;
          // Busy reset settles longer; ready pin may end it early
          if ((was_busy && (cnt >= BUSY_CYC || (cnt > 16'h_0004 && rdy_s2))) ||
              (!was_busy && cnt >= IDLE_CYC)) begin
            o_restart_needed <= was_busy & i_busy_op;
            cnt              <= 16'h_0000;
            state            <= ST_RH;
          end
        end
        ST_RH: begin
          cnt <= cnt + 16'h_0001;
          if (cnt >= `FPR_RH_CYC - 1)
            state <= ST_IDLE;
        end
        default: state <= ST_START;
      endcase
    end
  end
endmodule

/* File: bench/fpr_host_properties.sv */
`timescale 1ns/1ps
module fpr_chk (
  input wire        i_ref_clk,
  input wire        i_srst,
  input wire        o_ready,
  input wire        o_rd_valid,
  input wire        o_dev_standby,
  input wire [18:0] o_addr_pin,
  input wire [15:0] o_dq_oe_n,
  input wire        o_chip_enable_low,
  input wire        o_output_gate_low,
  input wire        o_write_strobe_low,
  input wire        o_array_restart_low
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  reg [4:0] low_cnt;
  reg [1:0] high_cnt;
  always @(posedge i_ref_clk) begin
    low_cnt <= (i_srst || o_array_restart_low) ? 5'h_00 : low_cnt + {4'h_0, low_cnt != 5'h_1f};
    high_cnt <= (i_srst || !o_array_restart_low) ? 2'h_0 : high_cnt + {1'h_0, high_cnt != 2'h_3};
  end
  sequence rd_open; $fell(o_output_gate_low); endsequence
  sequence rd_wait; (!o_chip_enable_low && !o_rd_valid) [*4]; endsequence
  standby_pins_a: assert property (o_dev_standby |-> o_chip_enable_low && o_array_restart_low)
    else $error("standby flag with device selected");
  ready_idle_a: assert property (o_ready |-> o_chip_enable_low && o_output_gate_low)
    else $error("idle with control pins active");
  select_time_a: assert property (rd_open |-> rd_wait ##[1:4] o_rd_valid)
    else $error("read data taken early or late");
  reset_width_a: assert property ($rose(o_array_restart_low) |-> low_cnt >= 5'h_19)
    else $error("reset pulse too short");
  reset_quiet_a: assert property (!o_array_restart_low |-> o_chip_enable_low && &o_dq_oe_n)
    else $error("access during reset pulse");
  read_delay_a: assert property (rd_open |-> high_cnt == 2'h_3)
    else $error("read too soon after reset");
  gate_drive_a: assert property (!(&o_dq_oe_n[14:0]) |-> o_output_gate_low)
    else $error("data driven with output gate active");
  addr_hold_a: assert property (rd_open |=> $stable(o_addr_pin) [*4])
    else $error("address moved during read");
endmodule
bind fpr_host fpr_chk u_chk (.*);

/* File: bench/fpr_flash_model.sv */
`timescale 1ns/1ps
`include "fpr_regs.vh"
module fpr_flash_model (
  input  wire        i_ref_clk,
  input  wire        i_prog,
  input  wire [18:0] i_addr_pin,
  input  wire [15:0] i_dq,
  input  wire        i_chip_enable_low,
  input  wire        i_output_gate_low,
  input  wire        i_write_strobe_low,
  input  wire        i_array_restart_low,
  input  wire        i_byte_low,
  output wire [15:0] o_dq,
  output reg         o_op_done_indicator = 1'h_1,
  output reg  [15:0] o_last_wr = 16'h_0000
);
  reg [15:0]  float_pat = 16'h_a5a5;
  reg [1:0]   acc_cnt = 2'h_0;
  reg [3:0]   settle = 4'h_0;
  reg         running = 1'h_0;
  reg  [19:0] prev_addr = 20'h_0_0000;
  reg  [2:0]  still_cnt = 3'h_0;
  reg  [15:0] held = 16'h_0000;
  // Byte mode counts the low address bit on DQ15 as part of the address
  wire [19:0] cur_addr = {i_addr_pin, !i_byte_low & i_dq[15]};
  // Sleep comes from address stability alone; control pins play no part
  wire        asleep = still_cnt == `FPR_SLEEP_CYC;
  wire        out_en = !i_chip_enable_low && !i_output_gate_low && i_array_restart_low;
  wire [7:0]  byte_q = {i_addr_pin[6:0], i_dq[15]} ^ 8'h_5a;
  wire [15:0] word = !i_byte_low ? {float_pat[15:8], byte_q} : i_addr_pin[15:0] ^ 16'h_5a5a;
  // Floating bus toggles so a stale value never passes
  assign o_dq = (out_en && acc_cnt == 2'h_3) ? (asleep ? held : word) : float_pat;
  always @(posedge i_ref_clk) begin
    float_pat <= ~float_pat;
    acc_cnt <= out_en ? acc_cnt + {1'h_0, acc_cnt != 2'h_3} : 2'h_0;
    prev_addr <= cur_addr;
    still_cnt <= (cur_addr != prev_addr) ? 3'h_0 : still_cnt + {2'h_0, !asleep};
    held <= asleep ? held : word;
    if (!i_array_restart_low) begin
      running <= 1'h_0;
      settle <= (running || settle != 4'h_0) ? 4'h_a : 4'h_0;
    end else begin
      running <= running || i_prog;
      settle <= settle - {3'h_0, settle != 4'h_0};
    end
    o_op_done_indicator <= !running && settle == 4'h_0;
    if (!i_write_strobe_low && !i_chip_enable_low && i_array_restart_low) begin
      o_last_wr <= i_dq;
    end
  end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  reg         i_ref_clk = 1'h_0;
  reg         i_srst, i_rd_req, i_wr_req, i_rst_req, i_byte_mode, i_busy_op, prog;
  reg  [19:0] i_addr;
  reg  [15:0] i_wdata;
  wire        o_ready, o_rd_valid, o_restart_needed, o_dev_standby, i_op_done_indicator;
  wire        o_chip_enable_low, o_output_gate_low, o_write_strobe_low;
  wire        o_array_restart_low, o_byte_low;
  wire [15:0] o_rdata, o_dq_out, o_dq_oe_n, dev_dq, last_wr;
  wire [4:0]  o_sector;
  wire [18:0] o_addr_pin;
  wire [15:0] i_dq_in = (~o_dq_oe_n & o_dq_out) | (o_dq_oe_n & dev_dq);
  integer     mismatches = 0;
  integer     tests_run = 0;
  fpr_host #(.BUSY_CYC(20), .IDLE_CYC(5)) DUT (.*);
  fpr_flash_model u_dev (.i_ref_clk(i_ref_clk), .i_prog(prog), .i_addr_pin(o_addr_pin),
    .i_dq(i_dq_in), .i_chip_enable_low(o_chip_enable_low), .i_output_gate_low(o_output_gate_low),
    .i_write_strobe_low(o_write_strobe_low), .i_array_restart_low(o_array_restart_low),
    .i_byte_low(o_byte_low), .o_dq(dev_dq), .o_op_done_indicator(i_op_done_indicator),
    .o_last_wr(last_wr));
  always #10 i_ref_clk = ~i_ref_clk;
  task summarize;
    begin
      if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [19:0] seen, input [19:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick;
    begin
      @(posedge i_ref_clk);
      #1;
    end
  endtask
  task wait_ready(output integer n);
    begin
      n = 0;
      while (o_ready !== 1'h_1 && n < 300) begin
        tick;
        n = n + 1;
      end
      if (n == 300) begin
        mismatches = mismatches + 1;
        summarize;
      end
    end
  endtask
  task rd(input [19:0] a, input bm, input [4:0] sec);
    integer n;
    begin
      i_addr = a;
      i_byte_mode = bm;
      i_rd_req = 1'h_1;
      tick;
      i_rd_req = 1'h_0;
      n = 0;
      while (o_rd_valid !== 1'h_1 && n < 20) begin
        tick;
        n = n + 1;
      end
      if (n == 20) begin
        mismatches = mismatches + 1;
        summarize;
      end
      chk(o_rdata & (bm ? 16'h_00ff : 16'h_ffff), bm ? a[7:0] ^ 8'h_5a : a[15:0] ^ 16'h_5a5a);
      chk(o_sector, sec);
      wait_ready(n);
    end
  endtask
  task t_sectors;
    integer s;
    begin
      for (s = 0; s < 15; s = s + 1) begin
        rd(s[0] ? {s[3:0], 16'h_0f0f} : {1'h_0, s[3:0], 15'h_7ab1}, s[0], s[4:0]);
      end
      rd(20'h_f_7fff, 1'h_1, 5'h_0f);
      rd(20'h_f_8000, 1'h_1, 5'h_10);
      rd(20'h_f_bfff, 1'h_1, 5'h_11);
      rd(20'h_f_c000, 1'h_1, 5'h_12);
      rd(20'h_7_8000, 1'h_0, 5'h_0f);
      rd(20'h_7_cfff, 1'h_0, 5'h_10);
      rd(20'h_7_d000, 1'h_0, 5'h_11);
      rd(20'h_7_ffff, 1'h_0, 5'h_12);
    end
  endtask
  task t_write;
    integer n;
    begin
      i_addr = 20'h_4_2000;
      i_byte_mode = 1'h_0;
      i_wdata = 16'h_c3a5;
      i_wr_req = 1'h_1;
      tick;
      i_wr_req = 1'h_0;
      wait_ready(n);
      chk(last_wr, 16'h_c3a5);
      chk(o_sector, 5'h_08);
      chk(o_dev_standby, 1'h_1);
    end
  endtask
  task do_rst(output integer n);
    begin
      i_rst_req = 1'h_1;
      tick;
      i_rst_req = 1'h_0;
      wait_ready(n);
    end
  endtask
  task t_resets;
    integer nb, ni;
    begin
      prog = 1'h_1;
      i_busy_op = 1'h_1;
      tick;
      prog = 1'h_0;
      do_rst(nb);
      chk(o_restart_needed, 1'h_1);
      i_busy_op = 1'h_0;
      do_rst(ni);
      chk(o_restart_needed, 1'h_0);
      chk(nb > ni, 1'h_1);
      rd(20'h_0_1234, 1'h_0, 5'h_00);
    end
  endtask
  initial begin
    {i_rd_req, i_wr_req, i_rst_req, i_byte_mode, i_busy_op, prog} = 6'h_00;
    i_addr = 20'h_0_0000;
    i_wdata = 16'h_0000;
    i_srst = 1'h_1;
    repeat (8) tick;
    i_srst = 1'h_0;
    do_rst_wait;
  end
  task do_rst_wait;
    integer n;
    begin
      wait_ready(n);
      t_sectors;
      t_write;
      t_resets;
      summarize;
    end
  endtask
endmodule
